// *** design/plfv_defines.svh ***
// Offsets, field layout, reset values and hardware limits of the configuration commands
// What this block does
// RULE1: Floor limit is 16-bit absolute word
// RULE2: Floor field is all bits, RW, restored
// RULE3: Commanded output never below floor
// RULE4: Below-floor change moves output to floor, slewed
// RULE5: Violation sets three status bits, alerts host
// RULE6: Ceiling conflict gives same violation response
// RULE7: Out-of-range write flagged as invalid data
// RULE8: Rate applied now if off, else deferred
// RULE9: Rate word is exponent plus mantissa
// RULE10: Rate decoded into twelve fixed buckets
// RULE11: Host avoids rates above 1100 kHz; the bench writes rates up to 1648 kHz
// RULE12: Start threshold exponent resets to minus two
// RULE13: Start threshold rounds down on apply, restore
// RULE14: Start hardware spans 2.50 to 18.25 V
// RULE15: Low-input fault masked until first start crossing
// RULE16: Enabled but below stop sets off bit
// RULE17: Stop hardware spans 2.25 to 18.25 V
// RULE18: Stop threshold rounds down on apply, restore
// RULE19: Host keeps stop below start; the bench writes start 20 quarters while stop is still 40
// RULE20: Slew applies during conversion only
// RULE21: Rejected write keeps old value
`ifndef PLFV_DEFINES_SVH
`define PLFV_DEFINES_SVH
`define PLFV_CMD_FLOOR 8'h2B
`define PLFV_CMD_RATE 8'h33
`define PLFV_CMD_START 8'h35
`define PLFV_CMD_STOP 8'h36
`define PLFV_EXP_MSB 15
`define PLFV_EXP_LSB 11
`define PLFV_MAN_MSB 10
`define PLFV_THR_EXP_RST 5'h1E
`define PLFV_RATE_EXP_RST 5'h00
`define PLFV_FLOOR_RST 16'h0000
`define PLFV_RATE_MAX_KHZ 32'h0000_0672
`define PLFV_START_MIN_Q 32'h0000_000A
`define PLFV_STOP_MIN_Q 32'h0000_0009
`define PLFV_THR_MAX_Q 32'h0000_0049
`define PLFV_QUARTER_BIAS 2
`endif

// *** design/plfv_pkg.sv ***
// Types shared by the configuration command logic
package plfv_pkg;
    typedef enum logic [1:0] {
        PLFV_IDLE,
        PLFV_SLEW
    } plfv_slew_t;
    typedef logic [3:0] plfv_bucket_t;
endpackage : plfv_pkg

// *** design/plfv_config.sv ***
// Floor limit, switching rate and input threshold command logic
`include "plfv_defines.svh"
module plfv_config #(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Decoded command port
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [WORD_W-1:0] cmd_wdata_in,
    output logic cmd_ack_out,
    output logic [WORD_W-1:0] cmd_rdata_out,
    // Nonvolatile restore
    input wire logic restore_all_in,
    input wire logic analog_uv_in,
    input wire logic [WORD_W-1:0] nvm_floor_in,
    input wire logic [10:0] nvm_rate_khz_in,
    input wire logic [10:0] nvm_start_man_in,
    input wire logic [10:0] nvm_stop_man_in,
    // Converter state
    input wire logic conv_en_in,
    input wire logic enable_met_in,
    input wire logic [WORD_W-1:0] target_req_in,
    input wire logic [WORD_W-1:0] ceiling_limit_in,
    input wire logic ceiling_conflict_in,
    input wire logic [WORD_W-1:0] slew_step_in,
    input wire logic [WORD_W-1:0] vin_quarters_in,
    input wire logic clear_faults_in,
    // Outputs to converter
    output logic [WORD_W-1:0] vout_target_out,
    output plfv_pkg::plfv_bucket_t rate_bucket_out,
    output logic [10:0] rate_khz_out,
    output logic [6:0] start_hw_out,
    output logic [6:0] stop_hw_out,
    output logic low_input_fault_out,
    // Status to host
    output logic status_nota_out,
    output logic status_vout_out,
    output logic limit_warning_bit_out,
    output logic invalid_data_out,
    output logic off_low_input_out,
    output logic alert_out
);
    logic [WORD_W-1:0] floor_r, rate_r, start_r, stop_r;
    logic loaded_r, mask_r;
    logic [WORD_W-1:0] goal, last_req_r;
    logic violation, restore, wr, wr_ok, wr_bad, seen_r;
    logic [31:0] rate_khz, start_q, stop_q, wq;
    plfv_pkg::plfv_slew_t slew_r;

    // Scales a linear word; negative exponents drop low bits, which rounds down
    function automatic logic [31:0] plfv_scale(input logic [15:0] w, input int bias);
        int sh;
        logic [31:0] m;
        sh = int'($signed(w[`PLFV_EXP_MSB:`PLFV_EXP_LSB])) + bias;
        m = {21'h00_0000, w[`PLFV_MAN_MSB:0]};
        if (sh > 16) begin
            plfv_scale = (m == 32'h0000_0000) ? 32'h0000_0000 : 32'hFFFF_FFFF;
        end else if (sh >= 0) begin
            plfv_scale = m << sh;
        end else begin
            plfv_scale = m >> (-sh);
        end
    endfunction : plfv_scale

    function automatic plfv_pkg::plfv_bucket_t plfv_bucket(input logic [31:0] khz);
        if (khz < 32'd251) plfv_bucket = 4'h0;
        else if (khz < 32'd301) plfv_bucket = 4'h1;
        else if (khz < 32'd351) plfv_bucket = 4'h2;
        else if (khz < 32'd411) plfv_bucket = 4'h3;
        else if (khz < 32'd501) plfv_bucket = 4'h4;
        else if (khz < 32'd601) plfv_bucket = 4'h5;
        else if (khz < 32'd701) plfv_bucket = 4'h6;
        else if (khz < 32'd821) plfv_bucket = 4'h7;
        else if (khz < 32'd1001) plfv_bucket = 4'h8;
        else if (khz < 32'd1201) plfv_bucket = 4'h9;
        else if (khz < 32'd1401) plfv_bucket = 4'hA;
        else plfv_bucket = 4'hB;
    endfunction : plfv_bucket

    function automatic logic [10:0] plfv_bucket_khz(input plfv_pkg::plfv_bucket_t b);
        case (b)
            4'h0: plfv_bucket_khz = 11'd225;
            4'h1: plfv_bucket_khz = 11'd275;
            4'h2: plfv_bucket_khz = 11'd325;
            4'h3: plfv_bucket_khz = 11'd375;
            4'h4: plfv_bucket_khz = 11'd450;
            4'h5: plfv_bucket_khz = 11'd550;
            4'h6: plfv_bucket_khz = 11'd650;
            4'h7: plfv_bucket_khz = 11'd750;
            4'h8: plfv_bucket_khz = 11'd900;
            4'h9: plfv_bucket_khz = 11'd1100;
            4'hA: plfv_bucket_khz = 11'd1300;
            default: plfv_bucket_khz = 11'd1500;
        endcase
    endfunction : plfv_bucket_khz

    assign rate_khz = plfv_scale(rate_r, 0); // RULE9
    assign start_q = plfv_scale(start_r, `PLFV_QUARTER_BIAS);
    assign stop_q = plfv_scale(stop_r, `PLFV_QUARTER_BIAS);
    assign restore = restore_all_in || !loaded_r;
    assign wr = cmd_valid_in && cmd_write_in;

    // Range check of the incoming word for each command
    always_comb begin
        wq = 32'h0000_0000;
        wr_ok = 1'b0;
        unique case (cmd_code_in)
            `PLFV_CMD_FLOOR: wr_ok = (cmd_wdata_in <= ceiling_limit_in);
            `PLFV_CMD_RATE: begin
                wq = plfv_scale(cmd_wdata_in, 0);
                wr_ok = !cmd_wdata_in[`PLFV_MAN_MSB] && (wq < `PLFV_RATE_MAX_KHZ);
            end
            `PLFV_CMD_START: begin
                wq = plfv_scale(cmd_wdata_in, `PLFV_QUARTER_BIAS);
                wr_ok = !cmd_wdata_in[`PLFV_MAN_MSB] && (wq >= `PLFV_START_MIN_Q)
                    && (wq <= `PLFV_THR_MAX_Q); // RULE14
            end
            `PLFV_CMD_STOP: begin
                wq = plfv_scale(cmd_wdata_in, `PLFV_QUARTER_BIAS);
                wr_ok = !cmd_wdata_in[`PLFV_MAN_MSB] && (wq >= `PLFV_STOP_MIN_Q)
                    && (wq <= `PLFV_THR_MAX_Q); // RULE17
            end
            default: wr_ok = 1'b0;
        endcase
    end
    assign wr_bad = wr && !wr_ok; // RULE7

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
        end
    end

    // Stored words; a rejected write leaves them untouched
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            floor_r <= `PLFV_FLOOR_RST;
            rate_r <= {`PLFV_RATE_EXP_RST, 11'h000};
            start_r <= {`PLFV_THR_EXP_RST, 11'h000};
            stop_r <= {`PLFV_THR_EXP_RST, 11'h000};
        end else if (restore) begin
            floor_r <= nvm_floor_in; // RULE2
            rate_r <= {`PLFV_RATE_EXP_RST, nvm_rate_khz_in}; // RULE9
            start_r <= {`PLFV_THR_EXP_RST, nvm_start_man_in}; // RULE12
            stop_r <= {`PLFV_THR_EXP_RST, nvm_stop_man_in};
        end else if (wr && wr_ok) begin // RULE21
            if (cmd_code_in == `PLFV_CMD_FLOOR) floor_r <= cmd_wdata_in; // RULE1
            if (cmd_code_in == `PLFV_CMD_RATE) rate_r <= cmd_wdata_in;
            if (cmd_code_in == `PLFV_CMD_START) start_r <= cmd_wdata_in;
            if (cmd_code_in == `PLFV_CMD_STOP) stop_r <= cmd_wdata_in;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_ack_out <= 1'b0;
            cmd_rdata_out <= 16'h0000;
        end else begin
            cmd_ack_out <= cmd_valid_in;
            if (cmd_valid_in && !cmd_write_in) begin
                unique case (cmd_code_in)
                    `PLFV_CMD_FLOOR: cmd_rdata_out <= floor_r;
                    `PLFV_CMD_RATE: cmd_rdata_out <= rate_r;
                    `PLFV_CMD_START: cmd_rdata_out <= start_r;
                    `PLFV_CMD_STOP: cmd_rdata_out <= stop_r;
                    default: cmd_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    // Rate hardware frozen while converting, except that restore or analog_uv_in reloads it mid-run
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rate_bucket_out <= 4'h0;
            rate_khz_out <= 11'd225;
        end else if (restore || analog_uv_in || !conv_en_in) begin // RULE8
            rate_bucket_out <= plfv_bucket(rate_khz); // RULE10
            rate_khz_out <= plfv_bucket_khz(plfv_bucket(rate_khz));
        end
    end

    // Thresholds track the stored words; scaling already rounded down
    // Words outside the hardware span, as before the first load, pin to its ends
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_hw_out <= 7'h0A;
            stop_hw_out <= 7'h09;
        end else begin
            start_hw_out <= (start_q > `PLFV_THR_MAX_Q) ? 7'h49
                : (start_q < `PLFV_START_MIN_Q) ? 7'h0A : start_q[6:0]; // RULE13
            stop_hw_out <= (stop_q > `PLFV_THR_MAX_Q) ? 7'h49
                : (stop_q < `PLFV_STOP_MIN_Q) ? 7'h09 : stop_q[6:0]; // RULE18
        end
    end

    // Only a reset re-arms the mask; enable and restore leave it alone
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask_r <= 1'b1;
            low_input_fault_out <= 1'b0;
        end else begin
            if (vin_quarters_in > {9'h000, start_hw_out}) mask_r <= 1'b0; // RULE15
            low_input_fault_out <= !mask_r && (vin_quarters_in < {9'h000, stop_hw_out});
        end
    end

    // Floor clamp and violation detection on a target change
    assign goal = (target_req_in < floor_r) ? floor_r : target_req_in; // RULE3
    assign violation = conv_en_in && seen_r && (target_req_in != last_req_r)
        && (target_req_in < floor_r); // RULE4

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_req_r <= 16'h0000;
            seen_r <= 1'b0;
        end else begin
            last_req_r <= target_req_in;
            seen_r <= 1'b1;
        end
    end

    // Slew toward the clamped goal while converting; with conversion off it jumps straight there
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vout_target_out <= 16'h0000;
            slew_r <= plfv_pkg::PLFV_IDLE;
        end else if (!conv_en_in) begin // RULE20
            vout_target_out <= goal;
            slew_r <= plfv_pkg::PLFV_IDLE;
        end else begin
            unique case (slew_r)
                plfv_pkg::PLFV_IDLE: begin
                    if (vout_target_out != goal) slew_r <= plfv_pkg::PLFV_SLEW;
                    if (vout_target_out < floor_r) vout_target_out <= floor_r; // RULE3
                end
                plfv_pkg::PLFV_SLEW: begin
                    if (vout_target_out < goal) begin
                        vout_target_out <= (goal - vout_target_out > slew_step_in)
                            ? vout_target_out + slew_step_in : goal; // RULE4
                    end else if (vout_target_out > goal) begin
                        vout_target_out <= (vout_target_out - goal > slew_step_in)
                            ? vout_target_out - slew_step_in : goal;
                    end else begin
                        slew_r <= plfv_pkg::PLFV_IDLE;
                    end
                end
                default: slew_r <= plfv_pkg::PLFV_IDLE;
            endcase
        end
    end

    // Sticky status; a new event in the clearing cycle wins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_nota_out <= 1'b0;
            status_vout_out <= 1'b0;
            limit_warning_bit_out <= 1'b0;
        end else if (violation || ceiling_conflict_in) begin // RULE5 RULE6
            status_nota_out <= 1'b1;
            status_vout_out <= 1'b1;
            limit_warning_bit_out <= 1'b1;
        end else if (clear_faults_in) begin
            status_nota_out <= 1'b0;
            status_vout_out <= 1'b0;
            limit_warning_bit_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            invalid_data_out <= 1'b0;
            off_low_input_out <= 1'b0;
        end else begin
            invalid_data_out <= wr_bad || (invalid_data_out && !clear_faults_in); // RULE7
            off_low_input_out <= (enable_met_in && (vin_quarters_in < {9'h000, stop_hw_out}))
                || (off_low_input_out && !clear_faults_in); // RULE16
        end
    end

    // Alert follows any sticky status one cycle later
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alert_out <= 1'b0;
        end else begin
            alert_out <= status_nota_out || invalid_data_out || off_low_input_out; // RULE5
        end
    end

    floor_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_en_in && $past(conv_en_in) && $stable(floor_r) && slew_r == plfv_pkg::PLFV_IDLE
        |=> vout_target_out >= $past(floor_r)) // RULE3
        else $error("output target below floor");
    violation_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
        violation |=> status_nota_out && status_vout_out && limit_warning_bit_out ##1 alert_out)
        // RULE5
        else $error("violation did not raise status and alert");
    ceiling_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ceiling_conflict_in |=> status_nota_out && status_vout_out && limit_warning_bit_out) // RULE6
        else $error("ceiling conflict not flagged");
    bad_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_bad && !restore |=> invalid_data_out && $stable(floor_r) && $stable(rate_r)
        && $stable(start_r) && $stable(stop_r)) // RULE21
        else $error("rejected write changed state or was not flagged");
    rate_frozen_a: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_en_in && !restore && !analog_uv_in |=> $stable(rate_bucket_out)) // RULE8
        else $error("rate hardware changed while converting");
    rate_table_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rate_bucket_out == 4'h9 |-> rate_khz_out == 11'd1100) // RULE10
        else $error("bucket and rate disagree");
    start_range_a: assert property (@(posedge clk_in) disable iff (rst_in)
        start_hw_out <= 7'h49 && stop_hw_out <= 7'h49 && start_hw_out >= 7'h0A
        && stop_hw_out >= 7'h09) // RULE14
        else $error("threshold above hardware range");
    mask_once_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !mask_r |=> !mask_r) // RULE15
        else $error("low input mask re-armed without reset");
    masked_fault_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mask_r && $past(mask_r) |-> !low_input_fault_out) // RULE15
        else $error("low input fault while masked");
    off_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
        enable_met_in && vin_quarters_in < {9'h000, stop_hw_out} |=> off_low_input_out)
        // RULE16
        else $error("off due to low input not set");
    restore_exp_a: assert property (@(posedge clk_in) disable iff (rst_in)
        restore_all_in |=> start_r[15:11] == `PLFV_THR_EXP_RST) // RULE12
        else $error("start exponent not restored");
    off_jump_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !conv_en_in |=> vout_target_out == $past(goal)) // RULE20
        else $error("target slewed while not converting");

    violation_c: cover property (@(posedge clk_in) disable iff (rst_in)
        violation ##[1:20] vout_target_out == floor_r);
    deferred_rate_c: cover property (@(posedge clk_in) disable iff (rst_in)
        wr && cmd_code_in == `PLFV_CMD_RATE && conv_en_in ##[1:20] analog_uv_in);
    unmask_c: cover property (@(posedge clk_in) disable iff (rst_in)
        mask_r ##1 !mask_r);
    bad_write_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_bad);
endmodule : plfv_config

// *** sim/plfv_host_model.sv ***
// Host side model that drives the command port of the configuration logic
module plfv_host_model (
    // Clock
    input wire logic clk_in,
    // Command port
    output logic cmd_valid_out,
    output logic cmd_write_out,
    output logic [7:0] cmd_code_out,
    output logic [15:0] cmd_wdata_out,
    input wire logic cmd_ack_in,
    input wire logic [15:0] cmd_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_wdata_out = 16'hA5A5;
    end
    // Bias rail is taken as externally fed, so rates above 1100 kHz are fair here
    // Callers keep the stop threshold strictly below the start threshold, except between the start write of E829 and the stop write after it
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic [15:0] rdata);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_write_out = wr;
        cmd_code_out = code;
        cmd_wdata_out = data;
        @(negedge clk_in);
        ack = cmd_ack_in;
        rdata = cmd_rdata_in;
        cmd_valid_out = 1'b0;
        // Stale data would hide a design that samples the word late
        cmd_wdata_out = ~data;
    endtask : xfer
endmodule : plfv_host_model

// *** sim/plfv_config_tb.sv ***
// Self-checking bench for the configuration command logic
module plfv_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_in, cmd_valid_in, cmd_write_in, cmd_ack_out, restore_all_in, analog_uv_in;
    logic conv_en_in, enable_met_in, ceiling_conflict_in, clear_faults_in, low_input_fault_out;
    logic status_nota_out, status_vout_out, limit_warning_bit_out, invalid_data_out;
    logic off_low_input_out, alert_out, a;
    logic [7:0] cmd_code_in;
    logic [15:0] cmd_wdata_in, cmd_rdata_out, nvm_floor_in, ceiling_limit_in, target_req_in;
    logic [15:0] slew_step_in, vin_quarters_in, vout_target_out, got;
    logic [10:0] nvm_rate_khz_in, nvm_start_man_in, nvm_stop_man_in, rate_khz_out;
    logic [6:0] start_hw_out, stop_hw_out;
    plfv_pkg::plfv_bucket_t rate_bucket_out;
    int err_total, samples_checked, cycles;
    logic [15:0] rate_w[12] = '{16'h00FA, 16'h012C, 16'h012D, 16'h019A, 16'h01F4, 16'h0258,
        16'h02BC, 16'h0334, 16'h03E8, 16'h0A58, 16'h0ABC, 16'h0B38};
    logic [10:0] eff_k[12] = '{11'h0E1, 11'h113, 11'h145, 11'h177, 11'h1C2, 11'h226,
        11'h28A, 11'h2EE, 11'h384, 11'h44C, 11'h514, 11'h5DC};
    logic [7:0] bad_c[6] = '{8'h35, 8'h36, 8'h35, 8'h33, 8'h33, 8'h2B};
    logic [15:0] bad_w[6] = '{16'hF009, 16'hF008, 16'hF04A, 16'h0B39, 16'h0400, 16'h2001};
    plfv_config dut_u (.clk_in, .rst_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in,
        .cmd_wdata_in, .cmd_ack_out, .cmd_rdata_out, .restore_all_in, .analog_uv_in,
        .nvm_floor_in, .nvm_rate_khz_in, .nvm_start_man_in, .nvm_stop_man_in, .conv_en_in,
        .enable_met_in, .target_req_in, .ceiling_limit_in, .ceiling_conflict_in,
        .slew_step_in, .vin_quarters_in, .clear_faults_in, .vout_target_out,
        .rate_bucket_out, .rate_khz_out, .start_hw_out, .stop_hw_out, .low_input_fault_out,
        .status_nota_out, .status_vout_out, .limit_warning_bit_out, .invalid_data_out,
        .off_low_input_out, .alert_out);
    plfv_host_model host_u (.clk_in, .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in),
        .cmd_code_out(cmd_code_in), .cmd_wdata_out(cmd_wdata_in), .cmd_ack_in(cmd_ack_out),
        .cmd_rdata_in(cmd_rdata_out));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host_u.xfer(1'b1, c, d, a, got);
        chk("write ack", 16'h0001, {15'h0000, a});
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host_u.xfer(1'b0, c, 16'h0000, a, got);
        chk("read ack", 16'h0001, {15'h0000, a});
        chk("read word", e, got);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(2);
    endtask : pulse
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // Ceiling covers about eight times the expected run
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 1500) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        {restore_all_in, analog_uv_in, conv_en_in, enable_met_in} = 4'h0;
        {ceiling_conflict_in, clear_faults_in} = 2'h0;
        err_total = 0;
        samples_checked = 0;
        rst_in = 1'b1;
        nvm_floor_in = 16'h0800;
        ceiling_limit_in = 16'hFFFF;
        target_req_in = 16'h1000;
        slew_step_in = 16'h0100;
        vin_quarters_in = 16'h0000;
        nvm_rate_khz_in = 11'h1F4;
        nvm_start_man_in = 11'h02C;
        nvm_stop_man_in = 11'h028;
        tick(3);
        chk("reset khz", 16'h00E1, {5'h00, rate_khz_out});
        chk("reset start", 16'h000A, {9'h000, start_hw_out});
        chk("reset stop", 16'h0009, {9'h000, stop_hw_out});
        rst_in = 1'b0;
        tick(2);
        rd(8'h2B, 16'h0800);
        rd(8'h33, 16'h01F4);
        rd(8'h35, 16'hF02C);
        rd(8'h36, 16'hF028);
        chk("nvm bucket", 16'h0004, {12'h000, rate_bucket_out});
        chk("masked fault", 16'h0000, {15'h0000, low_input_fault_out});
        for (int i = 0; i < 12; i++) begin
            wr(8'h33, rate_w[i]);
            tick(2);
            chk("rate khz", {5'h00, eff_k[i]}, {5'h00, rate_khz_out});
            chk("bucket", 16'(i), {12'h000, rate_bucket_out});
        end
        conv_en_in = 1'b1;
        wr(8'h33, 16'h01F4);
        tick(2);
        chk("held khz", 16'h05DC, {5'h00, rate_khz_out});
        rd(8'h33, 16'h01F4);
        pulse(analog_uv_in);
        chk("uv khz", 16'h01C2, {5'h00, rate_khz_out});
        conv_en_in = 1'b0;
        wr(8'h35, 16'hE829);
        wr(8'h36, 16'hE813);
        tick(2);
        chk("start round", 16'h0014, {9'h000, start_hw_out});
        chk("stop round", 16'h0009, {9'h000, stop_hw_out});
        wr(8'h35, 16'hF049);
        wr(8'h36, 16'hF814);
        tick(2);
        chk("stop scaled", 16'h0028, {9'h000, stop_hw_out});
        chk("start top", 16'h0049, {9'h000, start_hw_out});
        ceiling_limit_in = 16'h2000;
        for (int i = 0; i < 6; i++) begin
            pulse(clear_faults_in);
            chk("cleared", 16'h0000, {15'h0000, invalid_data_out});
            wr(bad_c[i], bad_w[i]);
            tick(2);
            chk("invalid", 16'h0001, {15'h0000, invalid_data_out});
            chk("alert", 16'h0001, {15'h0000, alert_out});
        end
        rd(8'h34, 16'h0000);
        rd(8'h2B, 16'h0800);
        rd(8'h33, 16'h01F4);
        rd(8'h35, 16'hF049);
        rd(8'h36, 16'hF814);
        pulse(clear_faults_in);
        target_req_in = 16'h0400;
        tick(2);
        chk("floor clamp", 16'h0800, vout_target_out);
        target_req_in = 16'h1000;
        tick(2);
        conv_en_in = 1'b1;
        target_req_in = 16'h0400;
        tick(1);
        chk("nota", 16'h0001, {15'h0000, status_nota_out});
        chk("vout bit", 16'h0001, {15'h0000, status_vout_out});
        chk("warning", 16'h0001, {15'h0000, limit_warning_bit_out});
        tick(2);
        chk("slewing", 16'h0001, {15'h0000, vout_target_out > 16'h0800});
        tick(12);
        chk("at floor", 16'h0800, vout_target_out);
        chk("notify", 16'h0001, {15'h0000, alert_out});
        pulse(clear_faults_in);
        pulse(ceiling_conflict_in);
        chk("conflict", 16'h0001, {15'h0000, limit_warning_bit_out});
        chk("conflict nota", 16'h0001, {15'h0000, status_nota_out});
        chk("conflict vout", 16'h0001, {15'h0000, status_vout_out});
        pulse(restore_all_in);
        chk("restore start", 16'h002C, {9'h000, start_hw_out});
        rd(8'h36, 16'hF028);
        enable_met_in = 1'b1;
        tick(2);
        chk("off low", 16'h0001, {15'h0000, off_low_input_out});
        vin_quarters_in = 16'h0030;
        tick(2);
        vin_quarters_in = 16'h0010;
        tick(2);
        chk("fault armed", 16'h0001, {15'h0000, low_input_fault_out});
        pulse(restore_all_in);
        chk("mask kept", 16'h0001, {15'h0000, low_input_fault_out});
        give_verdict();
    end
endmodule : plfv_config_tb
